// ===== ecb_top.sv
// B-channel output control, counter and compare registers of a 10-bit timer.
// Assumes a single AHB-Lite master and that HREADY_IN is this slave's HREADYOUT.
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ecb_cfg.svh"

//
// Contract
// - Compare mode: pin starts at initial level.
// - PWM modes: initial bit picks active level.
// - Timer/counter mode ignores initial level bit.
// - Polarity bit inverts pin, except timer mode.
// - PWM modes: alignment field selects edge or centre matching.
// - Count low byte readable, writes ignored.
// - Count bits 9:8 read in high byte.
// - Compare A low byte, read/write, resets zero.
// - Compare A bits 9:8, read/write, reset zero.
// - Compare B low byte, read/write, resets zero.
// - Compare B bits 9:8, read/write, reset zero.
// - High byte bits 7:2 read zero.
// - Compare mode: run rising edge restores pin initial level.
// - Pin actions: high, low, toggle, none.
module ecb_top
  import ecb_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  output logic             OUTPUT_PIN_B_OUT,
  output logic             OUTPUT_PIN_B_OE_OUT
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ecb_bus_st_t           st_q, st_d;
  logic [7:0]            waddr_q, waddr_d;
  logic [31:0]           rdata_d;
  logic [31:0]           rd_val;
  logic                  addr_ph;
  ecb_ctrl_t             ctrl_q, ctrl_d;
  logic [`ECB_CNT_W-1:0] cmp_a_q, cmp_a_d;
  logic [`ECB_CNT_W-1:0] cmp_b_q, cmp_b_d;
  logic [`ECB_CNT_W-1:0] cnt_q, cnt_d;
  logic                  down_q, down_d;
  logic                  run_prev_q;
  logic                  lvl_q, lvl_d;
  logic                  sp_done_q, sp_done_d;
  logic                  pin_d, oe_d;
  logic                  run_rise;
  logic                  centre;
  logic                  pulse;
  logic                  tc_mode;
  logic                  raw;
  logic                  match_b;
  logic [1:0]            action;
  ecb_align_t            qual_align;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Zero wait states: read data are captured at the address phase, so the
  // data phase always completes in one cycle with an OKAY response.
  assign addr_ph = HSEL_IN && HREADY_IN && HTRANS_IN[1] && (HSIZE_IN == `ECB_HSIZE_WORD);

  always_comb begin
    case (HADDR_IN[7:0])
      `ECB_OFF_CNT_LO:  rd_val = {24'h000000, cnt_q[7:0]};
      `ECB_OFF_CNT_HI:  rd_val = {30'h00000000, cnt_q[9:8]};
      `ECB_OFF_CMPA_LO: rd_val = {24'h000000, cmp_a_q[7:0]};
      `ECB_OFF_CMPA_HI: rd_val = {30'h00000000, cmp_a_q[9:8]};
      `ECB_OFF_CMPB_LO: rd_val = {24'h000000, cmp_b_q[7:0]};
      `ECB_OFF_CMPB_HI: rd_val = {30'h00000000, cmp_b_q[9:8]};
      `ECB_OFF_CTRL:    rd_val = {23'h000000, ctrl_q};
      `ECB_OFF_STAT:    rd_val = {30'h00000000, down_q, lvl_q};
      default:          rd_val = 32'h00000000;
    endcase
  end

  always_comb begin
    st_d    = BUS_IDLE;
    waddr_d = waddr_q;
    rdata_d = 32'h00000000;
    if (addr_ph) begin
      waddr_d = HADDR_IN[7:0];
      if (HWRITE_IN) begin
        st_d = BUS_WR;
      end else begin
        st_d    = BUS_RD;
        rdata_d = rd_val;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q          <= BUS_IDLE;
      waddr_q       <= 8'h00;
      HRDATA_OUT    <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      st_q          <= st_d;
      waddr_q       <= waddr_d;
      HRDATA_OUT    <= rdata_d;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Count registers have no write path: the count belongs to the timer.
  always_comb begin
    ctrl_d  = ctrl_q;
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    if (st_q == BUS_WR) begin
      case (waddr_q)
        `ECB_OFF_CMPA_LO: cmp_a_d[7:0] = HWDATA_IN[7:0];
        `ECB_OFF_CMPA_HI: cmp_a_d[9:8] = HWDATA_IN[1:0];
        `ECB_OFF_CMPB_LO: cmp_b_d[7:0] = HWDATA_IN[7:0];
        `ECB_OFF_CMPB_HI: cmp_b_d[9:8] = HWDATA_IN[1:0];
        `ECB_OFF_CTRL:    ctrl_d = ecb_ctrl_t'(HWDATA_IN[`ECB_CTRL_W-1:0]);
        default:          ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q  <= ecb_ctrl_t'(`ECB_CTRL_RST);
      cmp_a_q <= `ECB_CMP_RST;
      cmp_b_q <= `ECB_CMP_RST;
    end else begin
      ctrl_q  <= ctrl_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
    end
  end

  // ****************************************************************
  // Counter and output pin
  // ****************************************************************
  assign tc_mode    = (ctrl_q.mode == MODE_TC);
  assign run_rise   = ctrl_q.timer_run && !run_prev_q;
  assign action     = {ctrl_q.b_pin_action_hi, ctrl_q.b_pin_action_lo};
  assign centre     = ((ctrl_q.mode == MODE_PWM) || (ctrl_q.mode == MODE_SP))
                      && (ctrl_q.pwm_alignment_select != ALIGN_EDGE);
  assign pulse      = (ctrl_q.mode == MODE_SP) || (action == 2'h3);
  assign qual_align = centre ? ctrl_q.pwm_alignment_select : ALIGN_EDGE;

  // The first running cycle still sees the count left by the last stop, so it
  // must not be allowed to match.
  ecb_cmp ecb_cmp_i (
    .clk_in    (SYS_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .en_in     (ctrl_q.timer_run && !run_rise),
    .cnt_in    (cnt_q),
    .down_in   (down_q),
    .align_in  (qual_align),
    .val_in    (cmp_b_q),
    .match_out (match_b)
  );

  // In PWM modes lvl_q means "active"; in compare mode it is the raw level.
  always_comb begin
    cnt_d     = cnt_q;
    down_d    = down_q;
    lvl_d     = lvl_q;
    sp_done_d = sp_done_q;
    if (run_rise) begin
      cnt_d     = `ECB_CNT_W'(0);
      down_d    = 1'b0;
      lvl_d     = (ctrl_q.mode == MODE_CMP) ? ctrl_q.b_initial_level_select : 1'b0;
      sp_done_d = 1'b0;
    end else begin
      if (ctrl_q.timer_run) begin
        if (down_q) begin
          down_d = (cnt_q != `ECB_CNT_W'(0));
          cnt_d  = down_d ? cnt_q - `ECB_CNT_W'(1) : `ECB_CNT_W'(1);
        end else if (cnt_q == `ECB_CNT_MAX) begin
          down_d = centre;
          cnt_d  = centre ? `ECB_CNT_MAX - `ECB_CNT_W'(1) : `ECB_CNT_W'(0);
        end else begin
          cnt_d = cnt_q + `ECB_CNT_W'(1);
        end
      end
      case (ctrl_q.mode)
        MODE_CMP: begin
          if (match_b) begin
            case (action)
              2'h1:    lvl_d = 1'b0;
              2'h2:    lvl_d = 1'b1;
              2'h3:    lvl_d = ~lvl_q;
              default: lvl_d = lvl_q;
            endcase
          end
        end
        MODE_PWM, MODE_SP: begin
          if ((ctrl_q.mode == MODE_PWM) && (action == 2'h0)) begin
            lvl_d = 1'b0;
          end else if ((ctrl_q.mode == MODE_PWM) && (action == 2'h1)) begin
            lvl_d = 1'b1;
          end else if (match_b) begin
            lvl_d     = (centre && !pulse) ? ~lvl_q : 1'b0;
            sp_done_d = sp_done_q || pulse;
          end else if (ctrl_q.timer_run && (cnt_q == `ECB_CNT_W'(0))
                       && !(pulse && sp_done_q)) begin
            lvl_d = 1'b1;
          end
        end
        default: lvl_d = 1'b0;
      endcase
    end
    // The initial level bit reaches the pin only outside timer/counter mode.
    raw   = (ctrl_q.mode == MODE_CMP) ? lvl_d : (lvl_d ~^ ctrl_q.b_initial_level_select);
    pin_d = tc_mode ? 1'b0 : (raw ^ ctrl_q.b_polarity_invert);
    oe_d  = !tc_mode;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_q               <= `ECB_CNT_W'(0);
      down_q              <= 1'b0;
      run_prev_q          <= 1'b0;
      lvl_q               <= 1'b0;
      sp_done_q           <= 1'b0;
      OUTPUT_PIN_B_OUT    <= 1'b0;
      OUTPUT_PIN_B_OE_OUT <= 1'b0;
    end else begin
      cnt_q               <= cnt_d;
      down_q              <= down_d;
      run_prev_q          <= ctrl_q.timer_run;
      lvl_q               <= lvl_d;
      sp_done_q           <= sp_done_d;
      OUTPUT_PIN_B_OUT    <= pin_d;
      OUTPUT_PIN_B_OE_OUT <= oe_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence s_write(logic [7:0] a);
    (st_q == BUS_WR) && (waddr_q == a);
  endsequence

  sequence s_read(logic [7:0] a);
    addr_ph && !HWRITE_IN && (HADDR_IN[7:0] == a);
  endsequence

  property p_cmp_hold;
    (ctrl_q.mode == MODE_CMP) && $stable(ctrl_q.mode) && $stable(ctrl_q.b_polarity_invert)
      && !match_b && !run_rise |=> $stable(OUTPUT_PIN_B_OUT);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("pin moved without a match");

  property p_pwm_forced;
    (ctrl_q.mode == MODE_PWM) && (action == 2'h1) && !run_rise
      |=> OUTPUT_PIN_B_OUT == $past(ctrl_q.b_initial_level_select ^ ctrl_q.b_polarity_invert);
  endproperty
  a_pwm_forced: assert property (p_pwm_forced) else $error("wrong PWM active level");

  property p_tc_quiet;
    tc_mode |=> !OUTPUT_PIN_B_OE_OUT && !OUTPUT_PIN_B_OUT;
  endproperty
  a_tc_quiet: assert property (p_tc_quiet) else $error("pin driven in timer mode");

  property p_pol_flip;
    (ctrl_q.mode == MODE_CMP) && $stable(ctrl_q.mode) && $changed(ctrl_q.b_polarity_invert)
      && !match_b && !run_rise |=> OUTPUT_PIN_B_OUT != $past(OUTPUT_PIN_B_OUT);
  endproperty
  a_pol_flip: assert property (p_pol_flip) else $error("polarity did not invert pin");

  property p_align_up;
    centre && (ctrl_q.pwm_alignment_select == ALIGN_UP) && down_q |=> !match_b;
  endproperty
  a_align_up: assert property (p_align_up) else $error("match while counting down");

  property p_cnt_ro;
    s_write(`ECB_OFF_CNT_LO) and (!ctrl_q.timer_run) |=> $stable(cnt_q);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count changed by a write");

  property p_cnt_hi;
    s_read(`ECB_OFF_CNT_HI) |=> HRDATA_OUT == {30'h00000000, $past(cnt_q[9:8])};
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte wrong");

  property p_cmpa_lo;
    s_write(`ECB_OFF_CMPA_LO) |=> cmp_a_q[7:0] == $past(HWDATA_IN[7:0]);
  endproperty
  a_cmpa_lo: assert property (p_cmpa_lo) else $error("compare A low not stored");

  property p_cmpb_hi;
    s_write(`ECB_OFF_CMPB_HI) |=> cmp_b_q[9:8] == $past(HWDATA_IN[1:0]);
  endproperty
  a_cmpb_hi: assert property (p_cmpb_hi) else $error("compare B high not stored");

  property p_hi_zero;
    (s_read(`ECB_OFF_CNT_HI) or s_read(`ECB_OFF_CMPA_HI) or s_read(`ECB_OFF_CMPB_HI))
      |=> HRDATA_OUT[31:2] == 30'h00000000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high byte upper bits not zero");

  property p_rise_init;
    run_rise && (ctrl_q.mode == MODE_CMP)
      |=> OUTPUT_PIN_B_OUT == $past(ctrl_q.b_initial_level_select ^ ctrl_q.b_polarity_invert);
  endproperty
  a_rise_init: assert property (p_rise_init) else $error("pin not restored at run");

  property p_act_high;
    (ctrl_q.mode == MODE_CMP) && (action == 2'h2) && match_b && !run_rise
      |=> OUTPUT_PIN_B_OUT == !$past(ctrl_q.b_polarity_invert);
  endproperty
  a_act_high: assert property (p_act_high) else $error("go-high action failed");

endmodule
`default_nettype wire

// ===== ecb_cfg.svh
// Offsets, field widths, reset values and counts for the B-channel compare block.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef ECB_CFG_SVH
`define ECB_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ECB_OFF_CNT_LO   8'h00
`define ECB_OFF_CNT_HI   8'h04
`define ECB_OFF_CMPA_LO  8'h08
`define ECB_OFF_CMPA_HI  8'h0C
`define ECB_OFF_CMPB_LO  8'h10
`define ECB_OFF_CMPB_HI  8'h14
`define ECB_OFF_CTRL     8'h18
`define ECB_OFF_STAT     8'h1C

// ****************************************************************
// Field widths, counts and reset values
// ****************************************************************
`define ECB_CNT_W        10
`define ECB_CNT_MAX      10'h3FF
`define ECB_CTRL_W       9
`define ECB_CTRL_RST     9'h000
`define ECB_CMP_RST      10'h000
`define ECB_HSIZE_WORD   3'h2

`endif

// ===== ecb_pkg.sv
// Types shared by the B-channel compare block and its comparator.
// Assumes ecb_cfg.svh is compiled alongside.
package ecb_pkg;

  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_TC  = 2'h1,
    MODE_PWM = 2'h2,
    MODE_SP  = 2'h3
  } ecb_mode_t;

  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'h0,
    ALIGN_UP   = 2'h1,
    ALIGN_DOWN = 2'h2,
    ALIGN_BOTH = 2'h3
  } ecb_align_t;

  // Control word, most significant field first.
  typedef struct packed {
    ecb_align_t pwm_alignment_select;
    logic       b_polarity_invert;
    logic       b_initial_level_select;
    logic       b_pin_action_hi;
    logic       b_pin_action_lo;
    ecb_mode_t  mode;
    logic       timer_run;
  } ecb_ctrl_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } ecb_bus_st_t;

endpackage

// ===== ecb_cmp.sv
// Ten-bit comparator that flags a match of the counter against a compare value.
// Assumes counter, direction and compare value are registers of one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "ecb_cfg.svh"

module ecb_cmp
  import ecb_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 en_in,
  input  wire logic [`ECB_CNT_W-1:0] cnt_in,
  input  wire logic                 down_in,
  input  wire ecb_align_t           align_in,
  input  wire logic [`ECB_CNT_W-1:0] val_in,
  output logic                      match_out
);

  logic match_d;

  always_comb begin
    match_d = 1'b0;
    if (en_in && (cnt_in == val_in)) begin
      case (align_in)
        ALIGN_UP:   match_d = ~down_in;
        ALIGN_DOWN: match_d = down_in;
        default:    match_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_out <= 1'b0;
    end else begin
      match_out <= match_d;
    end
  end

  property p_full_match;
    @(posedge clk_in) disable iff (!rst_n_in)
    match_out |-> ($past(cnt_in) == $past(val_in)) && $past(en_in);
  endproperty
  a_full_match: assert property (p_full_match) else $error("match without full equality");

endmodule
`default_nettype wire

// ===== ecb_top_tb.sv
// Self-checking bench for the B-channel compare block: registers, counter and output pin.
// Assumes ecb_pkg and ecb_cfg.svh are compiled first; the bench is the only bus master.
`timescale 1ns/10ps
`default_nettype none
`include "ecb_cfg.svh"

module ecb_top_tb
  import ecb_pkg::*;
();
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  logic        pin;
  logic        oe;
  int          bad_count;
  int          check_count;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ecb_top ecb_top_i (
    .SYS_CLK_IN          (clk),
    .RST_N_IN            (rst_n),
    .HSEL_IN             (hsel),
    .HADDR_IN            (haddr),
    .HTRANS_IN           (htrans),
    .HWRITE_IN           (hwrite),
    .HSIZE_IN            (hsize),
    .HWDATA_IN           (hwdata),
    .HREADY_IN           (hrdy),
    .HRDATA_OUT          (hrdata),
    .HREADYOUT_OUT       (hrdy),
    .HRESP_OUT           (hresp),
    .OUTPUT_PIN_B_OUT    (pin),
    .OUTPUT_PIN_B_OE_OUT (oe)
  );

  // ****************************************************************
  // Reporting and bus tasks
  // ****************************************************************
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // Returns just after the edge at which hready is sampled high.
  task automatic wait_rdy();
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      if (hrdy === 1'b1) return;
    end
    cmp({31'h0, hrdy}, 32'h1);
    end_of_test();
  endtask

  // Read data is taken at the edge closing the data phase, before any update lands.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdata = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rdata, exp);
  endtask

  // Run is written low first so that every start is a true rising edge.
  task automatic start(input ecb_ctrl_t c);
    c.timer_run = 1'b0;
    bus(1'b1, `ECB_OFF_CTRL, {23'h0, c});
    c.timer_run = 1'b1;
    bus(1'b1, `ECB_OFF_CTRL, {23'h0, c});
  endtask

  task automatic stop(input ecb_ctrl_t c);
    c.timer_run = 1'b0;
    bus(1'b1, `ECB_OFF_CTRL, {23'h0, c});
  endtask

  task automatic pin_chk(input logic exp);
    cmp({31'h0, pin}, {31'h0, exp});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    cmp({30'h0, oe, pin}, 32'h2);
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(4 * i), 32'h0);
    end
  endtask

  // All four are written before any is read, so an aliased decode shows up.
  task automatic t_regs();
    for (int i = 2; i < 6; i++) begin
      bus(1'b1, 8'(4 * i), 32'hFFFFFFA0 | i);
    end
    for (int i = 2; i < 6; i++) begin
      rd_chk(8'(4 * i), (i % 2) ? (32'hA0 | i) & 32'h3 : 32'hA0 | i);
    end
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0);
    rd_chk(`ECB_OFF_CMPA_LO, 32'hA2);
  endtask

  // Counter runs about 701 steps, so bits 9:8 are nonzero when read back.
  task automatic t_count();
    ecb_ctrl_t   c;
    logic [31:0] lo;
    logic [9:0]  v;
    c = '0;
    c.mode = MODE_TC;
    c.b_initial_level_select = 1'b1;
    c.b_polarity_invert = 1'b1;
    start(c);
    repeat (20) @(posedge clk);
    cmp({30'h0, oe, pin}, 32'h0);
    repeat (680) @(posedge clk);
    stop(c);
    bus(1'b1, `ECB_OFF_CNT_LO, 32'hFF);
    bus(1'b0, `ECB_OFF_CNT_LO, 32'h0);
    lo = rdata;
    bus(1'b0, `ECB_OFF_CNT_HI, 32'h0);
    cmp(rdata & 32'hFFFFFFFC, 32'h0);
    v = {rdata[1:0], lo[7:0]};
    cmp({31'h0, (v >= 10'd698 && v <= 10'd704)}, 32'h1);
    cmp(lo & 32'hFFFFFF00, 32'h0);
  endtask

  // Compare B is 0x105 and compare A 0x40: a match on the low byte only, or on A,
  // would move the pin long before the sample taken just before the true match.
  task automatic t_cmp();
    ecb_ctrl_t  c;
    logic [1:0] act;
    logic       e;
    bus(1'b1, `ECB_OFF_CMPB_LO, 32'h05);
    bus(1'b1, `ECB_OFF_CMPB_HI, 32'h01);
    bus(1'b1, `ECB_OFF_CMPA_LO, 32'h40);
    bus(1'b1, `ECB_OFF_CMPA_HI, 32'h00);
    for (int k = 0; k < 16; k++) begin
      act = 2'(k);
      c = '0;
      c.b_pin_action_hi = act[1];
      c.b_pin_action_lo = act[0];
      c.b_initial_level_select = k[2];
      c.b_polarity_invert = k[3];
      start(c);
      repeat (2) @(posedge clk);
      pin_chk(k[2] ^ k[3]);
      cmp({31'h0, oe}, 32'h1);
      repeat (250) @(posedge clk);
      pin_chk(k[2] ^ k[3]);
      repeat (46) @(posedge clk);
      e = (act == 2'h0) ? k[2] : (act == 2'h1) ? 1'b0 : (act == 2'h2) ? 1'b1 : ~k[2];
      pin_chk(e ^ k[3]);
      stop(c);
    end
  endtask

  // Pin sampled 128, 384, 1100 and 1900 cycles after start, compare B 0x100.
  task automatic pwm_row(input ecb_mode_t m, input logic [1:0] act, input ecb_align_t al,
                         input logic ini, input logic pol, input logic [3:0] e);
    ecb_ctrl_t c;
    c = '0;
    c.mode = m;
    c.b_pin_action_hi = act[1];
    c.b_pin_action_lo = act[0];
    c.pwm_alignment_select = al;
    c.b_initial_level_select = ini;
    c.b_polarity_invert = pol;
    start(c);
    repeat (128) @(posedge clk);
    pin_chk(e[3]);
    repeat (256) @(posedge clk);
    pin_chk(e[2]);
    repeat (716) @(posedge clk);
    pin_chk(e[1]);
    repeat (800) @(posedge clk);
    pin_chk(e[0]);
    stop(c);
  endtask

  task automatic t_pwm();
    bus(1'b1, `ECB_OFF_CMPB_LO, 32'h00);
    bus(1'b1, `ECB_OFF_CMPB_HI, 32'h01);
    pwm_row(MODE_PWM, 2'h2, ALIGN_EDGE, 1'b1, 1'b0, 4'b1010);
    pwm_row(MODE_PWM, 2'h2, ALIGN_EDGE, 1'b0, 1'b0, 4'b0101);
    pwm_row(MODE_PWM, 2'h2, ALIGN_EDGE, 1'b1, 1'b1, 4'b0101);
    pwm_row(MODE_PWM, 2'h2, ALIGN_UP, 1'b1, 1'b0, 4'b1000);
    pwm_row(MODE_PWM, 2'h2, ALIGN_DOWN, 1'b1, 1'b0, 4'b1110);
    pwm_row(MODE_PWM, 2'h2, ALIGN_BOTH, 1'b1, 1'b0, 4'b1001);
    pwm_row(MODE_PWM, 2'h0, ALIGN_EDGE, 1'b1, 1'b0, 4'b0000);
    pwm_row(MODE_PWM, 2'h1, ALIGN_EDGE, 1'b1, 1'b0, 4'b1111);
    pwm_row(MODE_SP, 2'h3, ALIGN_EDGE, 1'b1, 1'b0, 4'b1000);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = `ECB_HSIZE_WORD;
    bad_count = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_regs();
    // A second reset in mid-run must clear the compare values just written.
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_count();
    t_cmp();
    t_pwm();
    end_of_test();
  end
endmodule
`default_nettype wire
